// file: verilog/sensor_error_reporting_bist.v
`timescale 1ns/1ps
// Contract
// - Overvoltage forces error output; clears after supply falls and error read or reported.
// - Overvoltage detection only when locked; unlocked overvoltage enters programming, high-Z.
// - Threshold select 0 picks high rise/fall pair, 1 picks low pair.
// - SENT status bits stick until Manchester read or frame carrying set bit.
// - Sending a frame with set status bits clears those flags.
// - Status bit 0 ORs logic, radius, voltage-check, temperature and power-on flags.
// - Status bit 1 ORs undervoltage, overvoltage, saturation and angle-clamp flags.
// - Slow serial copy survives normal clears; cleared only after serial send.
// - Data selections 2, 8, 13 send diagnostic nibbles from independent copy.
// - Diagnostic nibbles share one bit for over- and undervoltage.
// - Digital error response select makes SENT/PWM high-Z while error present.
// - PWM error halves carrier and sends duty assigned to the flag.
// - Several PWM errors: only the highest-priority code is sent.
// - Analog error: output high-Z, high or low as configured.
// - Analog high-Z response held for configured number of angle updates.
// - Self-test lasts 200 ms; no communication while it runs.
// - Self-test end sets done bit regardless of outcome.
// - Self-test end sets pass bit only when checksum matches.
// - Computed checksum readable; expected signature is the fixed constant.
// - Self-test drives pseudo-random scan stimulus and compresses responses to checksum.
// - After undervoltage, SENT restarts with counter zero and first serial message.
// - SENT/PWM high-Z on overvoltage when access select is 2'b0X.
`include "err_report_consts.vh"
module sensor_error_reporting_bist #(
    parameter SELFTEST_CYCLES = (`SELFTEST_TIME_MS * `CLK_FREQ_KHZ)
) (
    input  wire                  i_sys_clk,
    input  wire                  i_sys_rst,
    input  wire [`EF_WIDTH-1:0]  i_error_raw,
    input  wire                  i_ovd_high_rise,
    input  wire                  i_ovd_high_fall,
    input  wire                  i_ovd_low_rise,
    input  wire                  i_ovd_low_fall,
    input  wire                  i_ovd_threshold_sel,
    input  wire                  i_eeprom_locked,
    input  wire [1:0]            i_output_mode,
    input  wire [3:0]            i_sent_data_sel,
    input  wire                  i_digital_error_response_select,
    input  wire [1:0]            i_analog_error_response,
    input  wire [3:0]            i_highz_hold_updates,
    input  wire [1:0]            i_programming_access_select,
    input  wire                  i_angle_update,
    input  wire                  i_manchester_err_read,
    input  wire                  i_sent_frame_sent,
    input  wire                  i_serial_msg_sent,
    input  wire                  i_serial_ready,
    input  wire                  i_selftest_start_bit,
    input  wire [31:0]           i_scan_response,
    output reg  [1:0]            o_sent_status_nibble,
    output reg  [7:0]            o_diag_nibbles,
    output reg  [`EF_WIDTH-1:0]  o_serial_err_data,
    output reg                   o_serial_err_valid,
    output reg                   o_pwm_half_freq,
    output reg  [6:0]            o_pwm_duty_pct,
    output reg  [1:0]            o_output_drive,
    output reg                   o_programming_mode,
    output reg                   o_sent_restart,
    output reg                   o_comm_block,
    output reg  [31:0]           o_scan_stimulus,
    output reg                   o_selftest_done_bit,
    output reg                   o_selftest_pass_bit,
    output reg  [31:0]           o_selftest_checksum
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    // PWM duty priority encoder: logic failure is highest priority, angle clamp lowest
    function [6:0] pwm_duty;
        input [`EF_WIDTH-1:0] f;
        begin
            if (f[`EF_LOGIC_FAILURE])     pwm_duty = `DUTY_STEP;
            else if (f[`EF_RADIUS_RANGE]) pwm_duty = 7'h14;
            else if (f[`EF_VOLTAGE_CHECK]) pwm_duty = 7'h1e;
            else if (f[`EF_TEMPERATURE])  pwm_duty = 7'h28;
            else if (f[`EF_POWER_ON])     pwm_duty = 7'h32;
            else if (f[`EF_UNDERVOLTAGE]) pwm_duty = 7'h3c;
            else if (f[`EF_OVERVOLTAGE])  pwm_duty = 7'h46;
            else if (f[`EF_SATURATION])   pwm_duty = 7'h50;
            else if (f[`EF_ANGLE_CLAMP])  pwm_duty = 7'h5a;
            else                          pwm_duty = `DUTY_NONE;
        end
    endfunction

    // Status bit 0 group
    function group0;
        input [`EF_WIDTH-1:0] f;
        begin
            group0 = f[`EF_LOGIC_FAILURE] | f[`EF_RADIUS_RANGE] | f[`EF_VOLTAGE_CHECK] |
                     f[`EF_TEMPERATURE] | f[`EF_POWER_ON];
        end
    endfunction

    // Status bit 1 group
    function group1;
        input [`EF_WIDTH-1:0] f;
        begin
            group1 = f[`EF_UNDERVOLTAGE] | f[`EF_OVERVOLTAGE] | f[`EF_SATURATION] |
                     f[`EF_ANGLE_CLAMP];
        end
    endfunction

    // Three-stage synchronisers for pin-side levels
    wire [`EF_WIDTH+3:0] pin_raw;
    reg  [`EF_WIDTH+3:0] s1_q;
    reg  [`EF_WIDTH+3:0] s2_q;
    reg  [`EF_WIDTH+3:0] s3_q;
    reg  [`EF_WIDTH+3:0] pin_q;
    assign pin_raw = {i_ovd_high_rise, i_ovd_high_fall, i_ovd_low_rise, i_ovd_low_fall,
                      i_error_raw};
    genvar g;
    generate
        for (g = 0; g < `EF_WIDTH + 4; g = g + 1) begin : g_sync
            always @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    pin_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        pin_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // Overvoltage comparator pair selection
    wire ov_rise = i_ovd_threshold_sel ? pin_q[`EF_WIDTH+1] : pin_q[`EF_WIDTH+3];
    wire ov_fall = i_ovd_threshold_sel ? pin_q[`EF_WIDTH]   : pin_q[`EF_WIDTH+2];
    reg  ov_cond_q;

    // Hysteresis: set above rise, release only once below fall
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ov_cond_q <= 1'b0;
        end else if (!i_eeprom_locked) begin
            ov_cond_q <= 1'b0;
        end else if (ov_rise) begin
            ov_cond_q <= 1'b1;
        end else if (!ov_fall) begin
            ov_cond_q <= 1'b0;
        end
    end

    // Programming mode on unlocked overvoltage
    wire prog_entry = !i_eeprom_locked && ov_rise;

    // Live error conditions including overvoltage
    reg [`EF_WIDTH-1:0] live;
    always @* begin
        live = pin_q[`EF_WIDTH-1:0];
        live[`EF_OVERVOLTAGE] = ov_cond_q;
    end

    // Reporting copies: status and serial each sticky on its own; diagnostic follows live conditions
    reg [`EF_WIDTH-1:0] err_q;
    reg [`EF_WIDTH-1:0] serial_q;
    reg [`EF_WIDTH-1:0] diag_q;
    wire [`EF_WIDTH-1:0] crit_mask;
    assign crit_mask = (`EF_WIDTH'h1 << `EF_OSC_FREQ) | (`EF_WIDTH'h1 << `EF_EEPROM_MULTI) |
                       (`EF_WIDTH'h1 << `EF_SHADOW_PARITY);

    // Frame with set status bits clears the reported groups
    reg [`EF_WIDTH-1:0] sent_clr;
    always @* begin
        sent_clr = {`EF_WIDTH{1'b0}};
        if (i_sent_frame_sent && o_sent_status_nibble[0]) begin
            sent_clr[`EF_LOGIC_FAILURE] = 1'b1;
            sent_clr[`EF_RADIUS_RANGE]  = 1'b1;
            sent_clr[`EF_VOLTAGE_CHECK] = 1'b1;
            sent_clr[`EF_TEMPERATURE]   = 1'b1;
            sent_clr[`EF_POWER_ON]      = 1'b1;
        end
        if (i_sent_frame_sent && o_sent_status_nibble[1]) begin
            sent_clr[`EF_UNDERVOLTAGE] = 1'b1;
            sent_clr[`EF_OVERVOLTAGE]  = 1'b1;
            sent_clr[`EF_SATURATION]   = 1'b1;
            sent_clr[`EF_ANGLE_CLAMP]  = 1'b1;
        end
        if (i_output_mode == `MODE_PWM && i_sent_frame_sent) begin
            sent_clr = ~crit_mask; // PWM cycle reports everything it shows
        end
    end

    wire [`EF_WIDTH-1:0] err_clr = i_manchester_err_read ? ~crit_mask : sent_clr;
    wire                 serial_take = o_serial_err_valid & i_serial_ready;

    // Sticky status and serial copies, live diagnostic copy; a live condition always wins over a clear
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            err_q    <= {`EF_WIDTH{1'b0}};
            serial_q <= {`EF_WIDTH{1'b0}};
            diag_q   <= {`EF_WIDTH{1'b0}};
        end else begin
            err_q    <= (err_q & ~err_clr) | live;
            serial_q <= (serial_take ? {`EF_WIDTH{1'b0}} : serial_q) | live;
            diag_q   <= live;
        end
    end

    // Slow serial copy queued through the FIFO to the serial message builder
    wire                 fifo_in_ready;
    wire                 fifo_out_valid;
    wire [`EF_WIDTH-1:0] fifo_out_data;
    reg                  push_q;
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            push_q <= 1'b0;
        end else begin
            push_q <= i_serial_msg_sent;
        end
    end
    err_fifo #(
        .WIDTH (`EF_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (push_q & (serial_q != {`EF_WIDTH{1'b0}})),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (serial_q),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (i_serial_ready & !o_serial_err_valid),
        .o_out_data  (fifo_out_data)
    );

    // Undervoltage exit detection
    reg uv_prev_q;
    wire any_err = |(err_q & ~(`EF_WIDTH'h1 << `EF_EEPROM_SINGLE));
    wire digital_mode = (i_output_mode == `MODE_SENT) || (i_output_mode == `MODE_PWM);
    wire diag_sel = (i_sent_data_sel == `SENT_SEL_DIAG_A) ||
                    (i_sent_data_sel == `SENT_SEL_DIAG_B) ||
                    (i_sent_data_sel == `SENT_SEL_DIAG_C);

    // Analog high-Z hold counter in angle updates
    reg [3:0] hold_q;
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            hold_q <= 4'h0;
        end else if (any_err && i_output_mode == `MODE_ANALOG) begin
            hold_q <= i_highz_hold_updates;
        end else if (i_angle_update && hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end
    end

    // Output reporting registers
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_sent_status_nibble <= 2'h0;
            o_diag_nibbles       <= 8'h00;
            o_serial_err_data    <= {`EF_WIDTH{1'b0}};
            o_serial_err_valid   <= 1'b0;
            o_pwm_half_freq      <= 1'b0;
            o_pwm_duty_pct       <= `DUTY_NONE;
            o_output_drive       <= `DRV_HIGHZ;
            o_programming_mode   <= 1'b0;
            o_sent_restart       <= 1'b0;
            uv_prev_q            <= 1'b0;
        end else begin
            o_sent_status_nibble <= {group1(err_q), group0(err_q)};
            o_diag_nibbles <= {8{diag_sel}} & {diag_q[`EF_ANGLE_CLAMP], diag_q[`EF_SATURATION],
                              diag_q[`EF_OVERVOLTAGE] | diag_q[`EF_UNDERVOLTAGE],
                              diag_q[`EF_POWER_ON], diag_q[`EF_TEMPERATURE],
                              diag_q[`EF_VOLTAGE_CHECK], diag_q[`EF_RADIUS_RANGE],
                              diag_q[`EF_LOGIC_FAILURE]};
            if (serial_take) begin
                o_serial_err_valid <= 1'b0;
            end else if (fifo_out_valid && !o_serial_err_valid) begin
                o_serial_err_valid <= 1'b1;
                o_serial_err_data  <= fifo_out_data;
            end
            o_pwm_half_freq <= (i_output_mode == `MODE_PWM) && any_err;
            o_pwm_duty_pct  <= (i_output_mode == `MODE_PWM) ? pwm_duty(err_q) : `DUTY_NONE;
            uv_prev_q       <= err_q[`EF_UNDERVOLTAGE];
            o_sent_restart  <= uv_prev_q && !err_q[`EF_UNDERVOLTAGE] &&
                               i_output_mode == `MODE_SENT;
            if (prog_entry) begin
                o_programming_mode <= 1'b1;
            end else if (i_eeprom_locked) begin
                o_programming_mode <= 1'b0;
            end
            if (prog_entry || o_programming_mode || |(err_q & crit_mask)) begin
                o_output_drive <= `DRV_HIGHZ;
            end else if (digital_mode) begin
                if (ov_cond_q && !i_programming_access_select[1]) begin
                    o_output_drive <= `DRV_HIGHZ;
                end else if (i_digital_error_response_select && |err_q) begin
                    o_output_drive <= `DRV_HIGHZ;
                end else begin
                    o_output_drive <= `DRV_NORMAL;
                end
            end else if (any_err || hold_q != 4'h0) begin
                case (i_analog_error_response)
                    `ARESP_HIGH: o_output_drive <= `DRV_HIGH;
                    `ARESP_LOW:  o_output_drive <= `DRV_LOW;
                    default:     o_output_drive <= `DRV_HIGHZ;
                endcase
            end else begin
                o_output_drive <= `DRV_NORMAL;
            end
        end
    end

    // Self-test sequencer: LFSR stimulus, MISR compaction
    reg [1:0]  st_q;
    reg [31:0] cnt_q;
    reg [31:0] lfsr_q;
    reg        start_prev_q;
    wire [31:0] misr_next = {o_selftest_checksum[30:0], 1'b0} ^
                            (o_selftest_checksum[31] ? `MISR_TAPS : 32'h0000_0000) ^
                            i_scan_response;
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            st_q                <= ST_IDLE;
            cnt_q               <= 32'h0000_0000;
            lfsr_q              <= `SELFTEST_SEED;
            start_prev_q        <= 1'b0;
            o_comm_block        <= 1'b0;
            o_scan_stimulus     <= 32'h0000_0000;
            o_selftest_done_bit <= 1'b0;
            o_selftest_pass_bit <= 1'b0;
            o_selftest_checksum <= 32'h0000_0000;
        end else begin
            start_prev_q <= i_selftest_start_bit;
            case (st_q)
                ST_IDLE: begin
                    if (i_selftest_start_bit && !start_prev_q && !i_eeprom_locked) begin
                        st_q                <= ST_RUN;
                        cnt_q               <= 32'h0000_0000;
                        lfsr_q              <= `SELFTEST_SEED;
                        o_selftest_checksum <= 32'h0000_0000;
                        o_selftest_done_bit <= 1'b0;
                        o_selftest_pass_bit <= 1'b0;
                        o_comm_block        <= 1'b1;
                    end
                end
                ST_RUN: begin
                    lfsr_q <= {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? `LFSR_TAPS : 32'h0);
                    o_scan_stimulus     <= lfsr_q;
                    o_selftest_checksum <= misr_next;
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q == SELFTEST_CYCLES - 1) begin
                        st_q                <= ST_IDLE;
                        o_comm_block        <= 1'b0;
                        o_selftest_done_bit <= 1'b1;
                        o_selftest_pass_bit <= (misr_next == `SELFTEST_SIGNATURE);
                    end
                end
                default: begin
                    st_q         <= ST_IDLE;
                    o_comm_block <= 1'b0;
                end
            endcase
        end
    end
endmodule // sensor_error_reporting_bist

// file: verilog/err_report_consts.vh
`ifndef ERR_REPORT_CONSTS_VH
`define ERR_REPORT_CONSTS_VH
// Error flag bit positions
`define EF_VOLTAGE_CHECK     0
`define EF_ANGLE_CLAMP       1
`define EF_TEMPERATURE       2
`define EF_SATURATION        3
`define EF_LOGIC_FAILURE     4
`define EF_RADIUS_RANGE      5
`define EF_POWER_ON          6
`define EF_EEPROM_SINGLE     7
`define EF_UNDERVOLTAGE      8
`define EF_OVERVOLTAGE       9
`define EF_EEPROM_MULTI      10
`define EF_SHADOW_PARITY     11
`define EF_OSC_FREQ          12
`define EF_WIDTH             13
// Output modes
`define MODE_SENT            2'h0
`define MODE_PWM             2'h1
`define MODE_ANALOG          2'h2
// Analog error response selections
`define ARESP_HIGHZ          2'h0
`define ARESP_HIGH           2'h1
`define ARESP_LOW            2'h2
// Output drive codes
`define DRV_NORMAL           2'h0
`define DRV_HIGHZ            2'h1
`define DRV_HIGH             2'h2
`define DRV_LOW              2'h3
// SENT data selections with extended diagnostic nibbles
`define SENT_SEL_DIAG_A      4'h2
`define SENT_SEL_DIAG_B      4'h8
`define SENT_SEL_DIAG_C      4'hd
// Self-test
`define SELFTEST_TIME_MS     200
`define CLK_FREQ_KHZ         100000
`define SELFTEST_SIGNATURE   32'h6c56c9ef
`define SELFTEST_SEED        32'h0000_0001
`define LFSR_TAPS            32'h8020_0003
`define MISR_TAPS            32'h04c1_1db7
// Duty codes in percent
`define DUTY_STEP            7'h0a
`define DUTY_NONE            7'h00
`define FIFO_DEPTH           4
`define FIFO_AW              2
`endif

// file: verilog/err_fifo.v
`timescale 1ns/1ps
module err_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             i_sys_clk,
    input  wire             i_sys_rst,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    // Honest full and empty from the fill count
    assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // Pointers and fill count
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // Storage write
    always @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
endmodule // err_fifo

// file: tb/host_rx_model.sv
`timescale 1ns/1ps
// Host side of the serial error words: stalls at random, flags any dropped word
module host_rx_model (
    input  wire        i_sys_clk,
    input  wire        i_stall,
    input  wire        i_valid,
    input  wire [12:0] i_data,
    output reg         o_ready = 1'b0,
    output reg         o_bad = 1'b0
);
    reg        pend_q = 1'b0;
    reg [12:0] held_q = 13'h0;
    reg [15:0] lfsr_q = 16'hace1;
    // An offered word must stay put until taken
    always @(posedge i_sys_clk) begin
        if (pend_q && (i_valid !== 1'b1 || i_data !== held_q))
            o_bad <= 1'b1;
        pend_q <= i_valid && !o_ready;
        held_q <= i_data;
        lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13]};
        o_ready <= !i_stall && lfsr_q[0];
    end
endmodule // host_rx_model

// file: tb/sensor_err_checker_assertions.sv
`timescale 1ns/1ps
`include "err_report_consts.vh"
module sensor_err_checker #(
    parameter SELFTEST_CYCLES = 50
) (
    input wire        i_sys_clk,
    input wire        i_sys_rst,
    input wire        i_manchester_err_read,
    input wire        i_sent_frame_sent,
    input wire [1:0]  o_sent_status_nibble,
    input wire        o_pwm_half_freq,
    input wire [6:0]  o_pwm_duty_pct,
    input wire        o_sent_restart,
    input wire        o_comm_block,
    input wire        o_selftest_done_bit,
    input wire        o_selftest_pass_bit,
    input wire [31:0] o_selftest_checksum
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    reg [31:0] run_q;
    wire       clr = i_manchester_err_read | i_sent_frame_sent;
    // Length of the self-test blackout
    always @(posedge i_sys_clk) begin
        run_q <= (i_sys_rst || !o_comm_block) ? 32'h0 : run_q + 32'h1;
    end
    chk_status_clear: assert property ($fell(o_sent_status_nibble[0]) ||
        $fell(o_sent_status_nibble[1]) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
        else $error("status bit dropped without a clear");
    chk_done_ends_run: assert property ($rose(o_selftest_done_bit) |->
        !o_comm_block && $past(o_comm_block)) else $error("done not at end of run");
    chk_busy_no_done: assert property (o_comm_block |-> !o_selftest_done_bit)
        else $error("done shown during run");
    chk_pass_sig: assert property ($rose(o_selftest_pass_bit) |->
        o_selftest_checksum == `SELFTEST_SIGNATURE) else $error("pass with wrong checksum");
    chk_run_max: assert property (o_comm_block |-> run_q < SELFTEST_CYCLES + 2)
        else $error("self-test too long");
    chk_run_min: assert property ($fell(o_comm_block) |->
        $past(run_q) >= SELFTEST_CYCLES - 2) else $error("self-test too short");
    chk_half_freq: assert property (o_pwm_duty_pct != 7'h00 |-> o_pwm_half_freq)
        else $error("duty code without half carrier");
    chk_duty_code: assert property (o_pwm_duty_pct % 10 == 0 && o_pwm_duty_pct <= 90)
        else $error("illegal duty code");
    chk_restart_pulse: assert property (o_sent_restart |=> !o_sent_restart)
        else $error("restart wider than one cycle");
    cov_done: cover property ($rose(o_selftest_done_bit));
    cov_both_bits: cover property (o_sent_status_nibble == 2'h3);
    cov_duty_low: cover property (o_pwm_duty_pct == 7'h5a);
endmodule // sensor_err_checker
bind sensor_error_reporting_bist sensor_err_checker #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_chk (.*);

// file: tb/test_sensor_error_reporting_bist.sv
`timescale 1ns/1ps
`include "err_report_consts.vh"
module test_sensor_error_reporting_bist;
    reg         i_sys_clk, i_sys_rst, i_ovd_threshold_sel, i_eeprom_locked, tick_en, stall;
    reg         i_digital_error_response_select, i_angle_update;
    wire        i_sent_frame_sent, i_serial_msg_sent, i_selftest_start_bit, i_manchester_err_read;
    reg  [12:0] i_error_raw, f;
    reg  [3:0]  cmp, i_sent_data_sel, pl, i_highz_hold_updates = 4'h3;
    reg  [1:0]  i_output_mode, i_analog_error_response, i_programming_access_select = 2'h0;
    reg  [31:0] i_scan_response, s;
    wire        i_ovd_high_rise = cmp[3], i_ovd_high_fall = cmp[2];
    wire        i_ovd_low_rise = cmp[1], i_ovd_low_fall = cmp[0];
    wire        i_serial_ready, o_serial_err_valid, o_pwm_half_freq, o_programming_mode, bad;
    wire        o_sent_restart, o_comm_block, o_selftest_done_bit, o_selftest_pass_bit;
    wire [1:0]  o_sent_status_nibble, o_output_drive;
    wire [7:0]  o_diag_nibbles;
    wire [12:0] o_serial_err_data;
    wire [6:0]  o_pwm_duty_pct;
    wire [31:0] o_scan_stimulus, o_selftest_checksum;
    int         n_mismatch, n_tests, k, j;
    int         pri[9] = '{4, 5, 0, 2, 6, 8, 9, 3, 1};
    assign {i_selftest_start_bit, i_serial_msg_sent, i_sent_frame_sent, i_manchester_err_read} = pl;
    sensor_error_reporting_bist #(.SELFTEST_CYCLES(50)) DUT (.*);
    host_rx_model u_host (.i_sys_clk, .i_stall(stall), .i_valid(o_serial_err_valid),
        .i_data(o_serial_err_data), .o_ready(i_serial_ready), .o_bad(bad));
    function [31:0] nx(input [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Expected status nibble, diagnostic byte and PWM duty for a flag set
    function [1:0] e_nib(input [12:0] x);
        e_nib = {x[8] | x[9] | x[3] | x[1], x[4] | x[5] | x[0] | x[2] | x[6]};
    endfunction
    function [7:0] e_diag(input [12:0] x);
        e_diag = {x[1], x[3], x[8] | x[9], x[6], x[2], x[0], x[5], x[4]};
    endfunction
    function [6:0] e_duty(input [12:0] x);
        e_duty = 7'h00;
        for (int i = 8; i >= 0; i--)
            if (x[pri[i]]) e_duty = 7'(10 * (i + 1));
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // One-cycle pulse: 0 read, 1 frame, 2 serial boundary, 3 self-test start
    task pulse(input int w);
        pl = 4'h1 << w;
        cyc(1);
        pl = 4'h0;
        cyc(1);
    endtask
    task results;
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // Random scan response, angle ticks and host stalls
    always @(negedge i_sys_clk) begin
        s <= nx(s);
        i_scan_response <= s;
        stall <= s[3];
        i_angle_update <= s[7] & tick_en;
    end
    initial begin
        s = 32'h0001_2bc4;
        {i_sys_rst, i_eeprom_locked, tick_en, pl} = 7'h70;
        {i_ovd_threshold_sel, i_digital_error_response_select} = 2'h0;
        {i_error_raw, cmp, i_output_mode, i_analog_error_response, i_sent_data_sel} = 25'h2;
        n_mismatch = 0;
        n_tests = 0;
        cyc(12);
        i_sys_rst = 1'b0;
        cyc(4);
        // Each status-group flag alone except overvoltage, then random mixes; reported, held, then cleared
        for (k = 0; k < 29; k++) begin
            i_output_mode = `MODE_SENT;
            i_sent_data_sel = (k % 3 == 0) ? 4'h2 : (k % 3 == 1) ? 4'h8 : 4'hd;
            f = ((k < 9) ? (13'h1 << pri[k]) : s[12:0]) & 13'h017f;
            i_error_raw = f;
            cyc(8);
            chk("status nibble", e_nib(f), o_sent_status_nibble);
            chk("diag nibbles", e_diag(f), o_diag_nibbles);
            i_output_mode = `MODE_PWM;
            cyc(3);
            chk("pwm duty", e_duty(f), o_pwm_duty_pct);
            chk("pwm half", e_duty(f) != 7'h00, o_pwm_half_freq);
            i_output_mode = `MODE_SENT;
            i_error_raw = 13'h0;
            cyc(8);
            pulse(2);
            chk("sticky nibble", e_nib(f), o_sent_status_nibble);
            pulse(k % 2);
            cyc(3);
            chk("cleared nibble", 2'h0, o_sent_status_nibble);
        end
        // Analog responses, then digital high-Z response
        for (k = 0; k < 4; k++) begin
            i_output_mode = (k < 3) ? `MODE_ANALOG : `MODE_SENT;
            i_analog_error_response = k[1:0];
            i_digital_error_response_select = (k == 3);
            tick_en = (k != 0);
            i_error_raw = 13'h0010;
            cyc(8);
            chk("error drive", (k < 3) ? k + 1 : 1, o_output_drive);
            i_error_raw = 13'h0;
            cyc(6);
            pulse(0);
            cyc(4);
            if (k == 0) chk("highz hold", `DRV_HIGHZ, o_output_drive);
            tick_en = 1'b1;
            cyc(60);
            pulse(0);
            cyc(4);
            chk("normal drive", `DRV_NORMAL, o_output_drive);
        end
        i_digital_error_response_select = 1'b0;
        i_ovd_threshold_sel = 1'b1;
        cmp = 4'h3;
        cyc(8);
        chk("ov low pair", 2'h2, o_sent_status_nibble);
        chk("ov drive", `DRV_HIGHZ, o_output_drive);
        i_programming_access_select = 2'h2;
        cyc(2);
        chk("ov access", `DRV_NORMAL, o_output_drive);
        i_programming_access_select = 2'h0;
        cmp = 4'h0;
        cyc(6);
        pulse(1);
        cyc(4);
        chk("ov release", 2'h0, o_sent_status_nibble);
        i_ovd_threshold_sel = 1'b0;
        cmp = 4'h3;
        cyc(8);
        chk("ov high pair", 2'h0, o_sent_status_nibble);
        pulse(3);
        cyc(2);
        chk("locked start", 1'b0, o_comm_block);
        i_eeprom_locked = 1'b0;
        cmp = 4'hc;
        cyc(8);
        chk("unlocked ov", 2'h0, o_sent_status_nibble);
        chk("prog mode", 1'b1, o_programming_mode);
        cmp = 4'h0;
        pulse(3);
        chk("run blocks", 1'b1, o_comm_block);
        for (j = 0; j < 200 && o_selftest_done_bit !== 1'b1; j++) cyc(1);
        if (j == 200) n_mismatch++;
        cyc(1);
        chk("run over", 1'b0, o_comm_block);
        chk("pass bit", 1'b0, o_selftest_pass_bit);
        chk("host handshake", 1'b0, bad);
        results();
    end
endmodule // test_sensor_error_reporting_bist
